// *** rtl/asb_pkg.sv ***
// shared constants of the auto-sleep and boot event flag block
// assumes a 10 MHz system clock and an 8-bit register space
package asb_pkg;

	// timing, figures in their own unit, then cycles at the system clock
	localparam int CLK_KHZ = 10000;
	localparam int BOOT_TIME_US = 500;
	localparam int BOOT_CYC = (BOOT_TIME_US * CLK_KHZ + 999) / 1000;
	localparam int SHORT_PULSE_US = 10;
	localparam int SHORT_PULSE_CYC = (SHORT_PULSE_US * CLK_KHZ + 999) / 1000;
	localparam int LONG_PULSE_MS = 2;
	localparam int LONG_PULSE_CYC = LONG_PULSE_MS * CLK_KHZ;

	// register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_SYS_STATE = 8'h14;
	localparam logic [7:0] ADDR_CFG_TWO = 8'h16;
	localparam logic [7:0] ADDR_SOFT_RST = 8'h17;
	localparam logic [7:0] ADDR_CFG_FOUR = 8'h18;
	localparam logic [7:0] ADDR_ODR = 8'h19;
	localparam logic [7:0] ADDR_WAKE_FLEX = 8'h1a;
	localparam logic [7:0] ADDR_SLEEP_FLEX = 8'h1b;
	localparam logic [7:0] ADDR_CNT_LO = 8'h1e;
	localparam logic [7:0] ADDR_CNT_HI = 8'h1f;
	localparam logic [7:0] ADDR_INT_EN = 8'h20;
	localparam logic [7:0] ADDR_PIN_SEL = 8'h21;

	// field positions
	localparam int BIT_BOOT = 0;
	localparam int BIT_ASLP = 1;
	localparam int SYS_ASLEEP = 0;
	localparam int SYS_DIR = 1;
	localparam int EN_BOOT = 0;
	localparam int EN_ASLP = 1;
	localparam int PIN_SECOND = 0;
	localparam int CFG4_POL = 0;
	localparam int CFG4_OD = 1;
	localparam int CFG2_WAKE_POWER_SETTING = 0;
	localparam int CFG2_SLEEP_POWER_SETTING = 2;
	localparam int CFG2_FLEX = 4;
	localparam int SOFT_RST_BIT = 0;

	// values after reset
	localparam logic [7:0] RST_INT_EN = 8'h01;
	localparam logic [7:0] RST_CFG_FOUR = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;

endpackage

// *** rtl/asb_event_flags.sv ***
// auto wake/sleep and boot-complete event flags with their register port
// assumes link requests are single pulses on link_clk, one at a time
//
// What this block does
// RQ1 - set auto-sleep flag, status bit 1, on every wake/sleep transition
// RQ2 - sleep after inactivity-count data-rate periods pass without any event
// RQ3 - in sleep apply sleep power and rate, or sleep flex settings
// RQ4 - any event wakes; then apply wake power and rate or flex settings
// RQ5 - system state register shows direction of the last transition
// RQ6 - reading the system state register clears the auto-sleep flag
// RQ7 - inactivity count of zero disables auto wake/sleep and its flag
// RQ8 - auto-sleep flag works only while its enable bit is one
// RQ9 - boot flag, status bit 0, low during boot, one afterward
// RQ10 - boot flag stays set until reset, soft reset or hibernate exit
// RQ11 - grounded strap: boot pulse on first pin, routing may pick second
// RQ12 - grounded strap with boot enabled: one pulse of short boot time
// RQ13 - strap at supply: active-low open-drain long pulse on second pin
// RQ14 - grounded strap: pulse active high after power-on or hibernate exit
// RQ15 - soft reset keeps polarity, driver type and pin routing
// RQ16 - reads and writes are refused until boot completes
// RQ17 - any event while awake restarts the inactivity count
`timescale 1ns/1ps

module asb_event_flags import asb_pkg::*; #(
	parameter logic [15:0] BOOT_CYCLES = 16'(BOOT_CYC),
	parameter logic [15:0] LONG_CYCLES = 16'(LONG_PULSE_CYC)
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// register port, link domain
	input wire logic link_clk,
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [7:0] link_addr,
	input wire logic [7:0] link_wdata,
	output logic [7:0] link_rdata,
	output logic link_done,
	output logic link_reject,
	output logic link_busy,
	// pins
	input wire logic boot_strap_select,
	input wire logic hibernate_exit,
	// sensing datapath, system domain
	input wire logic odr_tick,
	input wire logic event_active,
	// applied settings
	output logic asleep,
	output logic [1:0] power_setting,
	output logic [7:0] rate_setting,
	// interrupt pins
	output logic first_irq_pin_o,
	output logic first_irq_pin_oe,
	output logic second_irq_pin_o,
	output logic second_irq_pin_oe
);

	// drive of a pin: {out, oe}; open drain only pulls low
	function automatic logic [1:0] pin_drive(input logic act, input logic pol,
		input logic od);
		logic lvl;
		lvl = act ? pol : ~pol;
		pin_drive = od ? {1'b0, ~lvl} : {lvl, 1'b1};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link domain: capture a request and hold it across the crossing

	logic req_tgl_q;
	logic busy_q;
	logic l_wr_q;
	logic [7:0] l_addr_q;
	logic [7:0] l_wdata_q;
	logic ack_s1_q, ack_s2_q, ack_s3_q;
	logic [7:0] l_rdata_q;
	logic l_done_q;
	logic l_rej_q;
	logic ack_tgl_q;
	logic [7:0] s_rdata_q;
	logic s_rej_q;

	wire l_take = (link_wr | link_rd) & ~busy_q;
	wire l_ack = ack_s2_q ^ ack_s3_q;

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_tgl_q <= 1'b0;
			busy_q <= 1'b0;
			l_wr_q <= 1'b0;
			l_addr_q <= RST_ZERO;
			l_wdata_q <= RST_ZERO;
		end else if (l_take) begin
			req_tgl_q <= ~req_tgl_q;
			busy_q <= 1'b1;
			l_wr_q <= link_wr;
			l_addr_q <= link_addr;
			l_wdata_q <= link_wdata;
		end else if (l_ack) begin
			busy_q <= 1'b0;
		end
	end

	// answer data is stable in the system domain once the ack toggles
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
			l_rdata_q <= RST_ZERO;
			l_done_q <= 1'b0;
			l_rej_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
			l_done_q <= l_ack;
			if (l_ack) begin
				l_rdata_q <= s_rdata_q;
				l_rej_q <= s_rej_q; // see RQ16
			end
		end
	end

	assign link_rdata = l_rdata_q;
	assign link_done = l_done_q;
	assign link_reject = l_rej_q;
	assign link_busy = busy_q;

	////////////////////////////////////////////////////////////////////////
	// system domain: synchronisers

	logic req_s1_q, req_s2_q, req_s3_q;
	logic hib_s1_q, hib_s2_q, hib_s3_q;
	logic strap_s1_q, strap_s2_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			hib_s1_q <= 1'b0;
			hib_s2_q <= 1'b0;
			hib_s3_q <= 1'b0;
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			hib_s1_q <= hibernate_exit;
			hib_s2_q <= hib_s1_q;
			hib_s3_q <= hib_s2_q;
			strap_s1_q <= boot_strap_select;
			strap_s2_q <= strap_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register decode

	logic boot_done_q;
	logic [7:0] int_en_q, pin_sel_q, cfg2_q, cfg4_q, odr_q;
	logic [7:0] wake_flex_q, sleep_flex_q, cnt_lo_q, cnt_hi_q;
	logic asleep_q, dir_q, aslp_flag_q;

	wire s_req = req_s2_q ^ req_s3_q;
	wire s_ok = s_req & boot_done_q; // see RQ16
	wire wr_hit = s_ok & l_wr_q;
	wire rd_hit = s_ok & ~l_wr_q;
	wire soft_rst = wr_hit & (l_addr_q == ADDR_SOFT_RST) & l_wdata_q[SOFT_RST_BIT];
	wire hib_exit = hib_s2_q & ~hib_s3_q;
	wire restart = soft_rst | hib_exit;
	wire rd_state = rd_hit & (l_addr_q == ADDR_SYS_STATE);

	logic [7:0] status_w, state_w, rdata_w;
	always_comb begin
		status_w = RST_ZERO;
		status_w[BIT_BOOT] = boot_done_q; // see RQ9
		status_w[BIT_ASLP] = aslp_flag_q;
		state_w = RST_ZERO;
		state_w[SYS_ASLEEP] = asleep_q;
		state_w[SYS_DIR] = dir_q; // see RQ5
	end

	assign rdata_w = (l_addr_q == ADDR_STATUS) ? status_w :
		(l_addr_q == ADDR_SYS_STATE) ? state_w :
		(l_addr_q == ADDR_CFG_TWO) ? cfg2_q :
		(l_addr_q == ADDR_CFG_FOUR) ? cfg4_q :
		(l_addr_q == ADDR_ODR) ? odr_q :
		(l_addr_q == ADDR_WAKE_FLEX) ? wake_flex_q :
		(l_addr_q == ADDR_SLEEP_FLEX) ? sleep_flex_q :
		(l_addr_q == ADDR_CNT_LO) ? cnt_lo_q :
		(l_addr_q == ADDR_CNT_HI) ? cnt_hi_q :
		(l_addr_q == ADDR_INT_EN) ? int_en_q :
		(l_addr_q == ADDR_PIN_SEL) ? pin_sel_q : RST_ZERO;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_tgl_q <= 1'b0;
			s_rdata_q <= RST_ZERO;
			s_rej_q <= 1'b0;
		end else if (s_req) begin
			ack_tgl_q <= ~ack_tgl_q;
			s_rdata_q <= rd_hit ? rdata_w : RST_ZERO;
			s_rej_q <= ~boot_done_q; // see RQ16
		end
	end

	// soft reset clears plain settings; hibernate exit clears all
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			int_en_q <= RST_INT_EN;
			cfg2_q <= RST_ZERO;
			odr_q <= RST_ZERO;
			wake_flex_q <= RST_ZERO;
			sleep_flex_q <= RST_ZERO;
			cnt_lo_q <= RST_ZERO;
			cnt_hi_q <= RST_ZERO;
		end else if (restart) begin
			int_en_q <= RST_INT_EN;
			cfg2_q <= RST_ZERO;
			odr_q <= RST_ZERO;
			wake_flex_q <= RST_ZERO;
			sleep_flex_q <= RST_ZERO;
			cnt_lo_q <= RST_ZERO;
			cnt_hi_q <= RST_ZERO;
		end else if (wr_hit) begin
			if (l_addr_q == ADDR_INT_EN) int_en_q <= l_wdata_q;
			if (l_addr_q == ADDR_CFG_TWO) cfg2_q <= l_wdata_q;
			if (l_addr_q == ADDR_ODR) odr_q <= l_wdata_q;
			if (l_addr_q == ADDR_WAKE_FLEX) wake_flex_q <= l_wdata_q;
			if (l_addr_q == ADDR_SLEEP_FLEX) sleep_flex_q <= l_wdata_q;
			if (l_addr_q == ADDR_CNT_LO) cnt_lo_q <= l_wdata_q;
			if (l_addr_q == ADDR_CNT_HI) cnt_hi_q <= l_wdata_q;
		end
	end

	// polarity, driver and routing survive a soft reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg4_q <= RST_CFG_FOUR;
			pin_sel_q <= RST_ZERO;
		end else if (hib_exit) begin
			cfg4_q <= RST_CFG_FOUR; // see RQ14
			pin_sel_q <= RST_ZERO; // see RQ11
		end else if (wr_hit & ~soft_rst) begin // see RQ15
			if (l_addr_q == ADDR_CFG_FOUR) cfg4_q <= l_wdata_q;
			if (l_addr_q == ADDR_PIN_SEL) pin_sel_q <= l_wdata_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot sequence and boot pulse

	logic [15:0] boot_cnt_q;
	logic [15:0] pulse_cnt_q;
	logic pulse_on_q, pulse_long_q;
	wire boot_fin = ~boot_done_q & (boot_cnt_q == 16'h0001);
	wire pulse_go = boot_fin & (strap_s2_q | int_en_q[EN_BOOT]); // see RQ12
	wire [15:0] pulse_len = strap_s2_q ? LONG_CYCLES : 16'(SHORT_PULSE_CYC);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			boot_cnt_q <= BOOT_CYCLES;
			boot_done_q <= 1'b0;
		end else if (restart) begin
			boot_cnt_q <= BOOT_CYCLES; // see RQ10
			boot_done_q <= 1'b0;
		end else if (boot_fin) begin
			boot_done_q <= 1'b1; // see RQ9
		end else if (!boot_done_q) begin
			boot_cnt_q <= boot_cnt_q - 16'h0001;
		end
	end

	// strap is read at boot completion, well after reset release
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pulse_on_q <= 1'b0;
			pulse_long_q <= 1'b0;
			pulse_cnt_q <= 16'h0000;
		end else if (restart) begin
			pulse_on_q <= 1'b0;
		end else if (pulse_go) begin
			pulse_on_q <= 1'b1;
			pulse_long_q <= strap_s2_q; // see RQ13
			pulse_cnt_q <= pulse_len;
		end else if (pulse_on_q) begin
			pulse_cnt_q <= pulse_cnt_q - 16'h0001;
			if (pulse_cnt_q == 16'h0001) pulse_on_q <= 1'b0;
		end
	end

	wire to_second = pin_sel_q[PIN_SECOND]; // see RQ11
	wire act_first = pulse_on_q & ~pulse_long_q & ~to_second;
	wire act_second = pulse_on_q & (pulse_long_q | to_second);
	wire pol_w = cfg4_q[CFG4_POL];
	wire od_w = cfg4_q[CFG4_OD];
	wire [1:0] drv_first = pin_drive(act_first, pol_w, od_w);
	// long pulse is always active low and open drain
	wire [1:0] drv_second = pulse_long_q ? pin_drive(act_second, 1'b0, 1'b1) :
		pin_drive(act_second, pol_w, od_w); // see RQ13

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			first_irq_pin_o <= 1'b0;
			first_irq_pin_oe <= 1'b1;
			second_irq_pin_o <= 1'b0;
			second_irq_pin_oe <= 1'b1;
		end else begin
			{first_irq_pin_o, first_irq_pin_oe} <= drv_first;
			{second_irq_pin_o, second_irq_pin_oe} <= drv_second;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// auto wake/sleep

	logic [15:0] idle_cnt_q;
	wire [15:0] limit_w = {cnt_hi_q, cnt_lo_q};
	wire aslp_on = (limit_w != 16'h0000) & boot_done_q; // see RQ7
	wire aslp_en = aslp_on & int_en_q[EN_ASLP]; // see RQ8
	wire go_sleep = aslp_on & ~asleep_q & odr_tick & ~event_active &
		(idle_cnt_q == limit_w - 16'h0001); // see RQ2
	wire go_wake = aslp_on & asleep_q & event_active; // see RQ4

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			idle_cnt_q <= 16'h0000;
		end else if (!aslp_on | asleep_q | event_active | go_sleep) begin
			idle_cnt_q <= 16'h0000; // see RQ17
		end else if (odr_tick) begin
			idle_cnt_q <= idle_cnt_q + 16'h0001;
		end
	end

	// a transition in the cycle of the clearing read keeps the flag set
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			asleep_q <= 1'b0;
			dir_q <= 1'b0;
			aslp_flag_q <= 1'b0;
		end else begin
			if (!aslp_on) asleep_q <= 1'b0;
			else if (go_sleep | go_wake) asleep_q <= go_sleep;
			if (go_sleep | go_wake) dir_q <= go_sleep; // see RQ5
			if (!aslp_en) aslp_flag_q <= 1'b0;
			else if (go_sleep | go_wake) aslp_flag_q <= 1'b1; // see RQ1
			else if (rd_state) aslp_flag_q <= 1'b0; // see RQ6
		end
	end

	wire flex_w = cfg2_q[CFG2_FLEX];
	wire [1:0] pm_w = asleep_q ? cfg2_q[CFG2_SLEEP_POWER_SETTING +: 2] : cfg2_q[CFG2_WAKE_POWER_SETTING +: 2];
	wire [7:0] odr_sel = asleep_q ? {4'h0, odr_q[7:4]} : {4'h0, odr_q[3:0]};
	wire [7:0] flex_sel = asleep_q ? sleep_flex_q : wake_flex_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			asleep <= 1'b0;
			power_setting <= 2'h0;
			rate_setting <= RST_ZERO;
		end else begin
			asleep <= asleep_q;
			power_setting <= pm_w; // see RQ3
			rate_setting <= flex_w ? flex_sel : odr_sel; // see RQ4
		end
	end

endmodule

// *** sim/asb_event_flags_properties.sv ***
// checker for the event flag block: sleep state, link answers, boot pulses
// bound to every asb_event_flags instance and sees only its ports
`timescale 1ns/1ps
module asb_event_flags_checker import asb_pkg::*; (
	// clocks and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic link_clk,
	// register port
	input wire logic [7:0] link_rdata,
	input wire logic link_done,
	input wire logic link_reject,
	input wire logic link_busy,
	// datapath and state
	input wire logic odr_tick,
	input wire logic event_active,
	input wire logic asleep,
	// pins
	input wire logic first_irq_pin_o,
	input wire logic second_irq_pin_o
);
	logic [15:0] hi1_q;
	logic [15:0] hi2_q;
	// high spans; an idle-high pin would wrap these, so pulses are judged on active-high use
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hi1_q <= 16'h0000;
			hi2_q <= 16'h0000;
		end else begin
			hi1_q <= first_irq_pin_o ? hi1_q + 16'h0001 : 16'h0000;
			hi2_q <= second_irq_pin_o ? hi2_q + 16'h0001 : 16'h0000;
		end
	end
	////////////////////////////////////////////////////////////
	property p_wake;
		@(posedge clk_sys) disable iff (!reset_n) asleep && event_active |-> ##2 !asleep;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on event");
	property p_sleep_tick;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(asleep) |-> $past(odr_tick, 2) && !$past(event_active, 2);
	endproperty
	a_sleep_tick: assert property (p_sleep_tick) else $error("sleep without quiet tick");
	property p_event_holds;
		@(posedge clk_sys) disable iff (!reset_n) event_active && !asleep |-> ##2 !asleep;
	endproperty
	a_event_holds: assert property (p_event_holds) else $error("slept during event");
	property p_pulse1;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(first_irq_pin_o) |-> hi1_q == 16'(SHORT_PULSE_CYC);
	endproperty
	a_pulse1: assert property (p_pulse1) else $error("first pin pulse width");
	property p_pulse2;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(second_irq_pin_o) |-> hi2_q == 16'(SHORT_PULSE_CYC);
	endproperty
	a_pulse2: assert property (p_pulse2) else $error("second pin pulse width");
	property p_answer;
		@(posedge link_clk) disable iff (!reset_n) $rose(link_busy) |-> ##[2:20] link_done;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer in time");
	property p_reject;
		@(posedge link_clk) disable iff (!reset_n) link_done && link_reject |-> link_rdata == 8'h00;
	endproperty
	a_reject: assert property (p_reject) else $error("refused access gave data");
	property p_done;
		@(posedge link_clk) disable iff (!reset_n) link_done |-> !link_busy ##1 !link_done;
	endproperty
	a_done: assert property (p_done) else $error("answer strobe shape");
endmodule

bind asb_event_flags asb_event_flags_checker i_checker (.clk_sys(clk_sys), .reset_n(reset_n),
	.link_clk(link_clk), .link_rdata(link_rdata), .link_done(link_done),
	.link_reject(link_reject), .link_busy(link_busy), .odr_tick(odr_tick),
	.event_active(event_active), .asleep(asleep), .first_irq_pin_o(first_irq_pin_o),
	.second_irq_pin_o(second_irq_pin_o));

// *** sim/asb_host_model.sv ***
// host processor model issuing single register accesses on the link
// assumes link_clk from the bench and the one-request-at-a-time contract
`timescale 1ns/1ps
module asb_host_model (
	// link answers
	input wire logic link_clk,
	input wire logic link_busy,
	input wire logic link_done,
	input wire logic link_reject,
	input wire logic [7:0] link_rdata,
	// link requests
	output logic link_wr,
	output logic link_rd,
	output logic [7:0] link_addr,
	output logic [7:0] link_wdata
);
	initial begin
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_addr = 8'h00;
		link_wdata = 8'h00;
	end
	// gap lets the host be slow; address and data are scrambled once answered
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input int gap, output logic [7:0] q, output logic rj);
		int n;
		n = 0;
		q = 8'hxx;
		rj = 1'bx;
		repeat (gap) @(posedge link_clk);
		while (link_busy !== 1'b0) @(posedge link_clk);
		#2;
		link_wr = wr;
		link_rd = !wr;
		link_addr = a;
		link_wdata = d;
		@(posedge link_clk);
		#2;
		link_wr = 1'b0;
		link_rd = 1'b0;
		while (link_done !== 1'b1 && n < 40) begin
			@(posedge link_clk);
			n++;
		end
		if (n < 40) begin
			q = link_rdata;
			rj = link_reject;
		end
		#2;
		link_addr = ~a;
		link_wdata = ~d;
	endtask
endmodule

// *** sim/asb_event_flags_bench.sv ***
// self-checking bench: boot, auto wake/sleep, soft reset, hibernate, strap
// short boot and long-pulse parameters keep the run brief
`timescale 1ns/1ps
module asb_event_flags_bench import asb_pkg::*;;
	localparam logic [15:0] LONG_SIM = 16'h001e;
	logic clk_sys, reset_n, link_clk, link_wr, link_rd, link_done, link_reject, link_busy;
	logic [7:0] link_addr, link_wdata, link_rdata, rate_setting, q;
	logic boot_strap_select, hibernate_exit, odr_tick, event_active, asleep, rj;
	logic [1:0] power_setting;
	logic p1o, p1oe, p2o, p2oe;
	int err_total, compares, p1, p2, len1, len2, lo2, h1, h2, l2;
	wire pin2_wire = p2oe ? p2o : 1'b1;

	asb_event_flags #(.BOOT_CYCLES(16'h0014), .LONG_CYCLES(LONG_SIM)) i_asb_event_flags (
		.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk), .link_wr(link_wr),
		.link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata),
		.link_rdata(link_rdata), .link_done(link_done), .link_reject(link_reject),
		.link_busy(link_busy), .boot_strap_select(boot_strap_select),
		.hibernate_exit(hibernate_exit), .odr_tick(odr_tick), .event_active(event_active),
		.asleep(asleep), .power_setting(power_setting), .rate_setting(rate_setting),
		.first_irq_pin_o(p1o), .first_irq_pin_oe(p1oe), .second_irq_pin_o(p2o),
		.second_irq_pin_oe(p2oe));
	asb_host_model i_host (.link_clk(link_clk), .link_busy(link_busy), .link_done(link_done),
		.link_reject(link_reject), .link_rdata(link_rdata), .link_wr(link_wr),
		.link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	// pulse monitor; second pin seen through its pull-up
	always @(posedge clk_sys) begin
		if (p1o === 1'b1) h1++;
		else if (h1 > 0) begin len1 = h1; p1++; h1 = 0; end
		if (p2o === 1'b1) h2++;
		else if (h2 > 0) begin len2 = h2; p2++; h2 = 0; end
		if (pin2_wire === 1'b0) l2++;
		else if (l2 > 0) begin lo2 = l2; l2 = 0; end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.acc(1'b1, a, d, 0, q, rj);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_host.acc(1'b0, a, 8'h00, 1, q, rj);
		chk({q[6:0], rj}, {exp[6:0], 1'b0});
		chk(q, exp);
	endtask
	// polls status until accesses stop being refused
	task automatic boot_wait();
		int n;
		n = 0;
		rj = 1'b1;
		while (rj !== 1'b0 && n < 50) begin
			i_host.acc(1'b0, ADDR_STATUS, 8'h00, 2, q, rj);
			n++;
		end
		chk(q, 8'h01);
		repeat (SHORT_PULSE_CYC + 5) @(posedge clk_sys);
	endtask
	task automatic tick(input logic ev);
		@(posedge clk_sys);
		#2;
		odr_tick = 1'b1;
		event_active = ev;
		@(posedge clk_sys);
		#2;
		odr_tick = 1'b0;
		event_active = 1'b0;
		repeat (3) @(posedge clk_sys);
		#2;
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		err_total++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////
	initial begin
		{reset_n, boot_strap_select, hibernate_exit, odr_tick, event_active} = 5'h00;
		repeat (8) @(posedge clk_sys);
		#2;
		reset_n = 1'b1;
		i_host.acc(1'b0, ADDR_STATUS, 8'h00, 0, q, rj);
		chk({q[6:0], rj}, 8'h01);
		boot_wait();
		chk(8'(p1), 8'h01);
		chk(8'(len1), 8'(SHORT_PULSE_CYC));
		rd(ADDR_CFG_FOUR, RST_CFG_FOUR);
		rd(ADDR_INT_EN, RST_INT_EN);
		$display("test boot done");
		wr(ADDR_CFG_TWO, 8'h09);
		wr(ADDR_ODR, 8'h52);
		wr(ADDR_INT_EN, 8'h03);
		wr(ADDR_CNT_LO, 8'h03);
		wr(ADDR_CNT_HI, 8'h00);
		for (int i = 0; i < 5; i++) tick(i == 2);
		chk({7'h00, asleep}, 8'h00);
		tick(1'b0);
		chk({5'h00, asleep, power_setting}, 8'h06);
		chk(rate_setting, 8'h05);
		rd(ADDR_STATUS, 8'h03);
		rd(ADDR_SYS_STATE, 8'h03);
		rd(ADDR_STATUS, 8'h01);
		tick(1'b1);
		chk({5'h00, asleep, power_setting}, 8'h01);
		chk(rate_setting, 8'h02);
		rd(ADDR_SYS_STATE, 8'h00);
		wr(ADDR_WAKE_FLEX, 8'ha5);
		wr(ADDR_CFG_TWO, 8'h19);
		tick(1'b1);
		chk(rate_setting, 8'ha5);
		wr(ADDR_INT_EN, 8'h01);
		repeat (4) tick(1'b0);
		chk({7'h00, asleep}, 8'h01);
		rd(ADDR_STATUS, 8'h01);
		wr(ADDR_INT_EN, 8'h03);
		wr(ADDR_CNT_LO, 8'h00);
		repeat (4) tick(1'b0);
		chk({7'h00, asleep}, 8'h00);
		$display("test auto sleep done");
		wr(ADDR_PIN_SEL, 8'h01);
		wr(ADDR_SOFT_RST, 8'h01);
		i_host.acc(1'b0, ADDR_STATUS, 8'h00, 0, q, rj);
		chk({q[6:0], rj}, 8'h01);
		boot_wait();
		chk(8'(p1), 8'h01);
		chk(8'(p2), 8'h01);
		chk(8'(len2), 8'(SHORT_PULSE_CYC));
		rd(ADDR_PIN_SEL, 8'h01);
		rd(ADDR_CFG_TWO, 8'h00);
		$display("test soft reset done");
		wr(ADDR_CFG_FOUR, 8'h02);
		@(posedge clk_sys);
		#2;
		chk({7'h00, p1oe}, 8'h00);
		hibernate_exit = 1'b1;
		repeat (4) @(posedge clk_sys);
		#2;
		hibernate_exit = 1'b0;
		boot_wait();
		chk(8'(p1), 8'h02);
		rd(ADDR_CFG_FOUR, RST_CFG_FOUR);
		rd(ADDR_PIN_SEL, 8'h00);
		$display("test hibernate done");
		boot_strap_select = 1'b1;
		wr(ADDR_CFG_FOUR, 8'h02);
		wr(ADDR_SOFT_RST, 8'h01);
		boot_wait();
		repeat (LONG_SIM + 10) @(posedge clk_sys);
		chk({6'h00, lo2 == int'(LONG_SIM), pin2_wire}, 8'h03);
		chk({8'(p1)}, 8'h02);
		$display("test strap done");
		wrap_up();
	end
endmodule
